// >>> core/tus_params.svh
// constants for the tape unit select and status block
`ifndef TUS_PARAMS_SVH
`define TUS_PARAMS_SVH
`define TUS_CLK_HZ 10000000
`define TUS_DLY_LONG_US 200
`define TUS_DLY_SHORT_US 150
`define TUS_DLY_LONG_CYC ((`TUS_DLY_LONG_US * (`TUS_CLK_HZ / 1000000)))
`define TUS_DLY_SHORT_CYC ((`TUS_DLY_SHORT_US * (`TUS_CLK_HZ / 1000000)))
`define TUS_CNT_W 12
`define TUS_UNITS 10
`define TUS_UNIT_W 4
`define TUS_REG_STATUS 4'h0
`define TUS_REG_SELECT 4'h1
`define TUS_REG_OPCTL 4'h2
`define TUS_REG_DIR 4'h3
`define TUS_ST_CTL_AVAIL 0
`define TUS_ST_UNIT_AVAIL 1
`define TUS_ST_SEL_DONE 2
`define TUS_ST_INTERLOCK 3
`define TUS_ST_RING 4
`define TUS_ST_FIRST_BLK 5
`define TUS_ST_REVERSE 6
`define TUS_ST_CTL_ERR 7
`define TUS_ST_IMPROPER 8
`define TUS_ST_FWD_REL 9
`define TUS_ST_BWD_REL 10
`define TUS_ST_SEL_ACT 11
`define TUS_ST_DUMMY 12
`define TUS_ST_TOO_MANY 13
`define TUS_ST_NONE_SEL 14
`endif

// >>> core/tus_pkg.sv
// types for the tape unit select and status block
package tus_pkg;
  typedef enum logic [1:0] {
    TUS_DLY_IDLE = 2'b00,
    TUS_DLY_RUN = 2'b01,
    TUS_DLY_DONE = 2'b10
  } tus_dly_state_t;
endpackage

// >>> core/tus_one_shot.sv
// one-shot delay counter retriggered by a start pulse
`timescale 1ns/10ps
`include "tus_params.svh"
module tus_one_shot #(
  parameter logic [`TUS_CNT_W-1:0] CYCLES = 12'h001
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic start_in,
  output logic busy_out,
  output logic end_pulse_out
);
  tus_pkg::tus_dly_state_t state_reg, state_next;
  logic [`TUS_CNT_W-1:0] cnt_reg, cnt_next;
  logic end_reg, end_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    end_next = 1'b0;
    unique case (state_reg)
      tus_pkg::TUS_DLY_IDLE, tus_pkg::TUS_DLY_DONE:
      begin
        if (start_in)
        begin
          state_next = tus_pkg::TUS_DLY_RUN;
          cnt_next = CYCLES - 12'h001;
        end
      end
      tus_pkg::TUS_DLY_RUN:
      begin
        if (start_in)
          cnt_next = CYCLES - 12'h001;
        else if (cnt_reg == 12'h000)
        begin
          state_next = tus_pkg::TUS_DLY_DONE;
          end_next = 1'b1;
        end
        else
          cnt_next = cnt_reg - 12'h001;
      end
      default:
        state_next = tus_pkg::TUS_DLY_IDLE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= tus_pkg::TUS_DLY_IDLE;
      cnt_reg <= 12'h000;
      end_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      end_reg <= end_next;
    end
  end

  assign busy_out = (state_reg == tus_pkg::TUS_DLY_RUN);
  assign end_pulse_out = end_reg;
endmodule

// >>> core/tus_select_checker.sv
// select checker: high when two or more inputs are active
`timescale 1ns/10ps
`include "tus_params.svh"
module tus_select_checker (
  input wire logic [`TUS_UNITS-1:0] sel_lines_in,
  input wire logic dummy_in,
  output logic multi_out
);
  logic [`TUS_UNITS:0] all_in;
  logic seen_one;
  logic seen_two;

  // running "one seen / two seen" so no adder is needed
  always_comb
  begin
    all_in = {dummy_in, sel_lines_in};
    seen_one = 1'b0;
    seen_two = 1'b0;
    for (int i = 0; i <= `TUS_UNITS; i++)
    begin
      seen_two = seen_two | (seen_one & all_in[i]);
      seen_one = seen_one | all_in[i];
    end
    multi_out = seen_two;
  end
endmodule

// >>> core/tus_unit_select.sv
// tape unit select register, select checking and status flags
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "tus_params.svh"
module tus_unit_select (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic PRESET_PULSE_IN,
  input wire logic SELECT_INSTR_STROBE_IN,
  input wire logic [`TUS_UNIT_W-1:0] TAPE_NUM_LSD_IN,
  input wire logic OPCTL_LOAD_IN,
  input wire logic [`TUS_UNIT_W-1:0] OPCTL_DIGIT_IN,
  input wire logic OPCTL_CHECK_BIT_IN,
  input wire logic PICKUP_DONE_PULSE_IN,
  input wire logic SELECTION_END_PULSE_IN,
  input wire logic PICKUP_COMPLETED_PULSE_IN,
  input wire logic STATUS_TEST_STROBE_IN,
  input wire logic SEL_DONE_TEST_IN,
  input wire logic CTL_ERR_TEST_IN,
  input wire logic FWD_RELEASE_RETURN_IN,
  input wire logic BWD_RELEASE_RETURN_IN,
  input wire logic MAIN_INTERLOCK_RETURN_IN,
  input wire logic NOT_PREPARED_RETURN_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] WDATA_IN,
  output logic [15:0] RDATA_OUT,
  output logic [`TUS_UNITS-1:0] UNIT_SELECT_OUT,
  output logic DUMMY_SELECT_OUT,
  output logic SELECTION_SAMPLE_PULSE_OUT,
  output logic UNIT_AVAILABLE_PULSE_OUT,
  output logic TOO_MANY_SELECTED_ERROR_OUT,
  output logic NONE_SELECTED_ERROR_OUT,
  output logic CTL_ERR_OUT,
  output logic CTL_ERR_TEST_RESULT_OUT,
  output logic IMPROPER_CONN_OUT,
  output logic CTL_AVAIL_OUT,
  output logic UNIT_AVAIL_OUT,
  output logic SEL_DONE_OUT,
  output logic SEL_DONE_TEST_RESULT_OUT,
  output logic INTERLOCK_OUT,
  output logic RING_IN_TAPE_OUT,
  output logic FIRST_BLOCK_OUT,
  output logic REVERSE_NEEDED_OUT,
  output logic FWD_RELEASE_FLAG_OUT,
  output logic BWD_RELEASE_FLAG_OUT,
  output logic DIR_FORWARD_DECODE_OUT,
  output logic DIR_BACKWARD_DECODE_OUT
);
  localparam logic [`TUS_CNT_W-1:0] LONG_CYC =
    `TUS_CNT_W'(`TUS_DLY_LONG_CYC);
  localparam logic [`TUS_CNT_W-1:0] SHORT_CYC =
    `TUS_CNT_W'(`TUS_DLY_SHORT_CYC);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [`TUS_UNIT_W-1:0] unit_reg, unit_next;
  logic sel_act_reg, sel_act_next;
  logic [`TUS_UNITS-1:0] sel_lines_reg, sel_lines_next;
  logic dummy_reg, dummy_next;
  logic ctl_avail_reg, ctl_avail_next;
  logic fwd_rel_reg, fwd_rel_next;
  logic bwd_rel_reg, bwd_rel_next;
  logic unit_avail_reg, unit_avail_next;
  logic sel_done_reg, sel_done_next;
  logic interlock_reg, interlock_next;
  logic ring_reg, ring_next;
  logic first_blk_reg, first_blk_next;
  logic reverse_reg, reverse_next;
  logic ctl_err_reg, ctl_err_next;
  logic improper_reg, improper_next;
  logic too_many_reg, too_many_next;
  logic none_sel_reg, none_sel_next;
  logic sample_reg, sample_next;
  logic avail_pulse_reg, avail_pulse_next;
  logic watch_reg, watch_next;
  logic [3:0] opctl_reg, opctl_next;
  logic chk_bit_reg, chk_bit_next;
  logic dir_bwd_reg, dir_bwd_next;
  logic err_res_reg, err_res_next;
  logic done_res_reg, done_res_next;
  logic [15:0] rdata_reg, rdata_next;
  logic dly_start;
  logic short_busy;
  logic long_end;
  logic multi;
  logic [15:0] status_word;

  // decode shared by the select lines and any later user
  function automatic logic [`TUS_UNITS-1:0] unit_decode(
    input logic [`TUS_UNIT_W-1:0] num, input logic en);
    logic [`TUS_UNITS-1:0] d;
    d = '0;
    for (int i = 0; i < `TUS_UNITS; i++)
      d[i] = en && (num == `TUS_UNIT_W'(i));
    return d;
  endfunction

  // ----------------------------------------------------------------
  // delays and checker
  // ----------------------------------------------------------------
  // delays start on every preset pulse, which also clears ctl-available
  assign dly_start = PRESET_PULSE_IN;

  tus_one_shot #(.CYCLES(LONG_CYC)) u_long (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .start_in(dly_start),
    .busy_out(),
    .end_pulse_out(long_end)
  );

  tus_one_shot #(.CYCLES(SHORT_CYC)) u_short (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .start_in(dly_start),
    .busy_out(short_busy),
    .end_pulse_out()
  );

  // checker looks at registered lines, so dummy set lands after the test
  tus_select_checker u_chk (
    .sel_lines_in(sel_lines_reg),
    .dummy_in(dummy_reg),
    .multi_out(multi)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    unit_next = unit_reg;
    sel_act_next = sel_act_reg;
    dummy_next = dummy_reg;
    ctl_avail_next = ctl_avail_reg;
    fwd_rel_next = fwd_rel_reg;
    bwd_rel_next = bwd_rel_reg;
    unit_avail_next = unit_avail_reg;
    sel_done_next = sel_done_reg;
    interlock_next = interlock_reg;
    ring_next = ring_reg;
    first_blk_next = first_blk_reg;
    reverse_next = reverse_reg;
    ctl_err_next = ctl_err_reg;
    improper_next = improper_reg;
    watch_next = watch_reg;
    opctl_next = opctl_reg;
    chk_bit_next = chk_bit_reg;
    err_res_next = 1'b0;
    done_res_next = 1'b0;
    sample_next = long_end;
    too_many_next = long_end && multi;
    none_sel_next = PICKUP_DONE_PULSE_IN && !multi;
    avail_pulse_next = 1'b0;

    // tests clear first so a same-cycle event still sets
    if (SEL_DONE_TEST_IN)
    begin
      done_res_next = sel_done_reg;
      sel_done_next = 1'b0;
    end
    if (CTL_ERR_TEST_IN)
    begin
      err_res_next = ctl_err_reg;
      ctl_err_next = 1'b0;
    end

    if (PRESET_PULSE_IN)
    begin
      unit_next = '0;
      sel_act_next = 1'b1;
      ctl_avail_next = 1'b0;
      unit_avail_next = 1'b0;
      sel_done_next = 1'b0;
      interlock_next = 1'b0;
      ring_next = 1'b0;
      first_blk_next = 1'b0;
      reverse_next = 1'b0;
      watch_next = 1'b0;
      opctl_next = '0;
      chk_bit_next = 1'b0;
    end
    else if (SELECT_INSTR_STROBE_IN)
      unit_next = TAPE_NUM_LSD_IN;

    if (OPCTL_LOAD_IN)
    begin
      opctl_next = OPCTL_DIGIT_IN;
      chk_bit_next = OPCTL_CHECK_BIT_IN;
    end

    if (SELECTION_END_PULSE_IN)
    begin
      unit_next = '0;
      sel_act_next = 1'b0;
    end

    if (PICKUP_COMPLETED_PULSE_IN)
      ctl_avail_next = 1'b1;

    // release capture: jammed clear in the short delay, blocked off-select
    if (short_busy || PRESET_PULSE_IN)
    begin
      fwd_rel_next = 1'b0;
      bwd_rel_next = 1'b0;
    end
    else if (sel_act_reg)
    begin
      if (FWD_RELEASE_RETURN_IN)
        fwd_rel_next = 1'b1;
      if (BWD_RELEASE_RETURN_IN)
        bwd_rel_next = 1'b1;
    end

    if (long_end)
    begin
      dummy_next = 1'b1;
      sel_done_next = 1'b1;
      watch_next = 1'b1;
      if (!MAIN_INTERLOCK_RETURN_IN)
        interlock_next = 1'b1;
      if (NOT_PREPARED_RETURN_IN)
        ring_next = 1'b1;
    end

    // level-held while watching; hazard: repeats each cycle a flag is set
    if (watch_reg && (fwd_rel_reg || bwd_rel_reg) && !PRESET_PULSE_IN)
    begin
      avail_pulse_next = 1'b1;
      unit_avail_next = 1'b1;
      interlock_next = 1'b0;
      sel_done_next = 1'b1;
    end

    if (PICKUP_DONE_PULSE_IN)
      dummy_next = 1'b0;

    if (too_many_next || none_sel_next)
    begin
      ctl_err_next = 1'b1;
      improper_next = 1'b1;
    end

    if (STATUS_TEST_STROBE_IN)
    begin
      if (fwd_rel_reg && bwd_rel_reg)
        first_blk_next = 1'b1;
      reverse_next = (chk_bit_reg && bwd_rel_reg && !fwd_rel_reg) ||
        (!chk_bit_reg && fwd_rel_reg && !bwd_rel_reg);
    end

    // improper-connection diagnostic is cleared by software only
    if (WR_IN && ADDR_IN == `TUS_REG_STATUS &&
        WDATA_IN[`TUS_ST_IMPROPER])
      improper_next = too_many_next || none_sel_next;

    sel_lines_next = unit_decode(unit_next, sel_act_next);
    // own flop so the backward decode leaves without an inverter
    dir_bwd_next = !chk_bit_next;
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb
  begin
    status_word = '0;
    status_word[`TUS_ST_CTL_AVAIL] = ctl_avail_reg;
    status_word[`TUS_ST_UNIT_AVAIL] = unit_avail_reg;
    status_word[`TUS_ST_SEL_DONE] = sel_done_reg;
    status_word[`TUS_ST_INTERLOCK] = interlock_reg;
    status_word[`TUS_ST_RING] = ring_reg;
    status_word[`TUS_ST_FIRST_BLK] = first_blk_reg;
    status_word[`TUS_ST_REVERSE] = reverse_reg;
    status_word[`TUS_ST_CTL_ERR] = ctl_err_reg;
    status_word[`TUS_ST_IMPROPER] = improper_reg;
    status_word[`TUS_ST_FWD_REL] = fwd_rel_reg;
    status_word[`TUS_ST_BWD_REL] = bwd_rel_reg;
    status_word[`TUS_ST_SEL_ACT] = sel_act_reg;
    status_word[`TUS_ST_DUMMY] = dummy_reg;
    status_word[`TUS_ST_TOO_MANY] = too_many_reg;
    status_word[`TUS_ST_NONE_SEL] = none_sel_reg;
    rdata_next = '0;
    if (RD_IN)
    begin
      unique case (ADDR_IN)
        `TUS_REG_STATUS: rdata_next = status_word;
        `TUS_REG_SELECT: rdata_next = {6'h00, sel_lines_reg};
        `TUS_REG_OPCTL: rdata_next = {11'h000, chk_bit_reg, opctl_reg};
        `TUS_REG_DIR: rdata_next = {14'h0000, !chk_bit_reg, chk_bit_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      unit_reg <= '0;
      sel_act_reg <= 1'b0;
      sel_lines_reg <= '0;
      dummy_reg <= 1'b0;
      ctl_avail_reg <= 1'b1;
      fwd_rel_reg <= 1'b0;
      bwd_rel_reg <= 1'b0;
      unit_avail_reg <= 1'b0;
      sel_done_reg <= 1'b0;
      interlock_reg <= 1'b0;
      ring_reg <= 1'b0;
      first_blk_reg <= 1'b0;
      reverse_reg <= 1'b0;
      ctl_err_reg <= 1'b0;
      improper_reg <= 1'b0;
      too_many_reg <= 1'b0;
      none_sel_reg <= 1'b0;
      sample_reg <= 1'b0;
      avail_pulse_reg <= 1'b0;
      watch_reg <= 1'b0;
      opctl_reg <= '0;
      chk_bit_reg <= 1'b0;
      dir_bwd_reg <= 1'b1;
      err_res_reg <= 1'b0;
      done_res_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else if (CE_IN)
    begin
      unit_reg <= unit_next;
      sel_act_reg <= sel_act_next;
      sel_lines_reg <= sel_lines_next;
      dummy_reg <= dummy_next;
      ctl_avail_reg <= ctl_avail_next;
      fwd_rel_reg <= fwd_rel_next;
      bwd_rel_reg <= bwd_rel_next;
      unit_avail_reg <= unit_avail_next;
      sel_done_reg <= sel_done_next;
      interlock_reg <= interlock_next;
      ring_reg <= ring_next;
      first_blk_reg <= first_blk_next;
      reverse_reg <= reverse_next;
      ctl_err_reg <= ctl_err_next;
      improper_reg <= improper_next;
      too_many_reg <= too_many_next;
      none_sel_reg <= none_sel_next;
      sample_reg <= sample_next;
      avail_pulse_reg <= avail_pulse_next;
      watch_reg <= watch_next;
      opctl_reg <= opctl_next;
      chk_bit_reg <= chk_bit_next;
      dir_bwd_reg <= dir_bwd_next;
      err_res_reg <= err_res_next;
      done_res_reg <= done_res_next;
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA_OUT = rdata_reg;
  assign UNIT_SELECT_OUT = sel_lines_reg;
  assign DUMMY_SELECT_OUT = dummy_reg;
  assign SELECTION_SAMPLE_PULSE_OUT = sample_reg;
  assign UNIT_AVAILABLE_PULSE_OUT = avail_pulse_reg;
  assign TOO_MANY_SELECTED_ERROR_OUT = too_many_reg;
  assign NONE_SELECTED_ERROR_OUT = none_sel_reg;
  assign CTL_ERR_OUT = ctl_err_reg;
  assign CTL_ERR_TEST_RESULT_OUT = err_res_reg;
  assign IMPROPER_CONN_OUT = improper_reg;
  assign CTL_AVAIL_OUT = ctl_avail_reg;
  assign UNIT_AVAIL_OUT = unit_avail_reg;
  assign SEL_DONE_OUT = sel_done_reg;
  assign SEL_DONE_TEST_RESULT_OUT = done_res_reg;
  assign INTERLOCK_OUT = interlock_reg;
  assign RING_IN_TAPE_OUT = ring_reg;
  assign FIRST_BLOCK_OUT = first_blk_reg;
  assign REVERSE_NEEDED_OUT = reverse_reg;
  assign FWD_RELEASE_FLAG_OUT = fwd_rel_reg;
  assign BWD_RELEASE_FLAG_OUT = bwd_rel_reg;
  assign DIR_FORWARD_DECODE_OUT = chk_bit_reg;
  assign DIR_BACKWARD_DECODE_OUT = dir_bwd_reg;
endmodule

// >>> test/tus_unit_select_chk.sv
// assertion checker for the tape unit select block
`timescale 1ns/10ps
`include "tus_params.svh"
module tus_unit_select_chk (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic PRESET_PULSE_IN,
  input wire logic PICKUP_DONE_PULSE_IN,
  input wire logic SELECTION_END_PULSE_IN,
  input wire logic PICKUP_COMPLETED_PULSE_IN,
  input wire logic STATUS_TEST_STROBE_IN,
  input wire logic [`TUS_UNITS-1:0] UNIT_SELECT_OUT,
  input wire logic DUMMY_SELECT_OUT,
  input wire logic SELECTION_SAMPLE_PULSE_OUT,
  input wire logic UNIT_AVAILABLE_PULSE_OUT,
  input wire logic NONE_SELECTED_ERROR_OUT,
  input wire logic CTL_ERR_OUT,
  input wire logic IMPROPER_CONN_OUT,
  input wire logic CTL_AVAIL_OUT,
  input wire logic UNIT_AVAIL_OUT,
  input wire logic SEL_DONE_OUT,
  input wire logic FIRST_BLOCK_OUT,
  input wire logic FWD_RELEASE_FLAG_OUT,
  input wire logic BWD_RELEASE_FLAG_OUT
);
  // cycles since the last preset, saturating
  logic [11:0] age_reg;
  logic [11:0] age_next;
  always_comb
  begin
    age_next = age_reg;
    if (CE_IN && PRESET_PULSE_IN)
      age_next = 12'h001;
    else if (CE_IN && age_reg != 12'h000 && age_reg != 12'hfff)
      age_next = age_reg + 12'h001;
  end
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
      age_reg <= 12'h000;
    else
      age_reg <= age_next;
  end
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  a_sel_onehot: assert property ($onehot0(UNIT_SELECT_OUT))
    else $error("more than one select line");
  // cleared register with the decoder on drives unit zero's line
  a_preset_clear: assert property (CE_IN && PRESET_PULSE_IN |=>
    UNIT_SELECT_OUT == 10'h001 && !CTL_AVAIL_OUT && !FIRST_BLOCK_OUT)
    else $error("preset did not clear select state");
  // one registering stage of slack on either side of the delay end
  a_sample_time: assert property (SELECTION_SAMPLE_PULSE_OUT |->
    age_reg >= 12'h7d0 && age_reg <= 12'h7d2)
    else $error("sample pulse off its delay");
  a_sample_done: assert property (SELECTION_SAMPLE_PULSE_OUT |->
    ##[0:1] SEL_DONE_OUT)
    else $error("sample pulse left selection incomplete");
  a_sample_dummy: assert property (SELECTION_SAMPLE_PULSE_OUT |->
    ##[0:1] DUMMY_SELECT_OUT)
    else $error("sample pulse did not set dummy");
  a_rel_held: assert property (age_reg >= 12'h002 &&
    age_reg <= 12'h5db |-> !FWD_RELEASE_FLAG_OUT && !BWD_RELEASE_FLAG_OUT)
    else $error("release flag set during hold");
  a_none_sel: assert property (CE_IN && PICKUP_DONE_PULSE_IN &&
    UNIT_SELECT_OUT == '0 |=>
    NONE_SELECTED_ERROR_OUT && CTL_ERR_OUT && IMPROPER_CONN_OUT)
    else $error("missing none selected error");
  a_dummy_clr: assert property (CE_IN && PICKUP_DONE_PULSE_IN |=>
    !DUMMY_SELECT_OUT)
    else $error("pickup done left dummy set");
  a_end_clear: assert property (CE_IN && SELECTION_END_PULSE_IN |=>
    UNIT_SELECT_OUT == '0)
    else $error("selection end left a line on");
  a_avail_set: assert property (UNIT_AVAILABLE_PULSE_OUT |->
    ##[0:1] (UNIT_AVAIL_OUT && SEL_DONE_OUT))
    else $error("available pulse without effect");
  a_ctl_avail: assert property (CE_IN && PICKUP_COMPLETED_PULSE_IN &&
    !PRESET_PULSE_IN |=> CTL_AVAIL_OUT)
    else $error("pickup completed did not free control");
  a_first_blk: assert property (CE_IN && STATUS_TEST_STROBE_IN &&
    FWD_RELEASE_FLAG_OUT && BWD_RELEASE_FLAG_OUT |=> FIRST_BLOCK_OUT)
    else $error("first block not set");
endmodule

bind tus_unit_select tus_unit_select_chk u_sva (.*);

// >>> test/tus_tape_unit_model.sv
// tape unit stand-in answering on its own select line
`timescale 1ns/10ps
`include "tus_params.svh"
module tus_tape_unit_model #(
  parameter int UNIT_ID = 3
) (
  input wire logic clk_in,
  input wire logic [`TUS_UNITS-1:0] sel_in,
  input wire logic [11:0] lat_in,
  input wire logic fwd_in,
  input wire logic bwd_in,
  input wire logic power_in,
  input wire logic ring_in,
  input wire logic stray_in,
  output logic fwd_ret_out,
  output logic bwd_ret_out,
  output logic mir_ret_out,
  output logic nep_ret_out
);
  // cycles spent selected; a slow unit answers late
  logic [11:0] up_reg;
  logic rdy;
  always_ff @(posedge clk_in)
  begin
    if (!sel_in[UNIT_ID])
      up_reg <= 12'h000;
    else if (up_reg != 12'hfff)
      up_reg <= up_reg + 12'h001;
  end
  // unselected return lines fall to the line pull-down
  assign rdy = sel_in[UNIT_ID] && up_reg >= lat_in;
  // stray is a commanded transient, present whether selected or not
  assign fwd_ret_out = (rdy && fwd_in) || stray_in;
  assign bwd_ret_out = rdy && bwd_in;
  assign mir_ret_out = rdy && power_in;
  assign nep_ret_out = rdy && ring_in;
endmodule

// >>> test/testbench.sv
// self-checking bench for the tape unit select block
`timescale 1ns/10ps
module testbench;
  logic SYS_CLK_IN = 1'b0;
  logic RST_N_IN, CE_IN, OPCTL_CHECK_BIT_IN, WR_IN, RD_IN;
  logic [3:0] TAPE_NUM_LSD_IN, OPCTL_DIGIT_IN, ADDR_IN;
  logic [15:0] WDATA_IN, RDATA_OUT, d;
  logic PRESET_PULSE_IN, SELECT_INSTR_STROBE_IN, OPCTL_LOAD_IN;
  logic PICKUP_DONE_PULSE_IN, SELECTION_END_PULSE_IN;
  logic PICKUP_COMPLETED_PULSE_IN, STATUS_TEST_STROBE_IN;
  logic SEL_DONE_TEST_IN, CTL_ERR_TEST_IN;
  logic FWD_RELEASE_RETURN_IN, BWD_RELEASE_RETURN_IN;
  logic MAIN_INTERLOCK_RETURN_IN, NOT_PREPARED_RETURN_IN;
  logic [9:0] UNIT_SELECT_OUT;
  logic DUMMY_SELECT_OUT, SELECTION_SAMPLE_PULSE_OUT;
  logic UNIT_AVAILABLE_PULSE_OUT, TOO_MANY_SELECTED_ERROR_OUT;
  logic NONE_SELECTED_ERROR_OUT, CTL_ERR_OUT, CTL_ERR_TEST_RESULT_OUT;
  logic IMPROPER_CONN_OUT, CTL_AVAIL_OUT, UNIT_AVAIL_OUT, SEL_DONE_OUT;
  logic SEL_DONE_TEST_RESULT_OUT, INTERLOCK_OUT, RING_IN_TAPE_OUT;
  logic FIRST_BLOCK_OUT, REVERSE_NEEDED_OUT, FWD_RELEASE_FLAG_OUT;
  logic BWD_RELEASE_FLAG_OUT, DIR_FORWARD_DECODE_OUT;
  logic DIR_BACKWARD_DECODE_OUT;
  logic [8:0] pv;
  logic [11:0] lat;
  logic pf, pb, pwr, ring, stray;
  int failures, total_checks;

  // pulse vector order, bit 8 first
  assign {CTL_ERR_TEST_IN, SEL_DONE_TEST_IN, STATUS_TEST_STROBE_IN,
    PICKUP_COMPLETED_PULSE_IN, SELECTION_END_PULSE_IN,
    PICKUP_DONE_PULSE_IN, OPCTL_LOAD_IN, SELECT_INSTR_STROBE_IN,
    PRESET_PULSE_IN} = pv;

  tus_unit_select dut (.*);

  tus_tape_unit_model #(.UNIT_ID(3)) unit3 (
    .clk_in(SYS_CLK_IN),
    .sel_in(UNIT_SELECT_OUT),
    .lat_in(lat),
    .fwd_in(pf),
    .bwd_in(pb),
    .power_in(pwr),
    .ring_in(ring),
    .stray_in(stray),
    .fwd_ret_out(FWD_RELEASE_RETURN_IN),
    .bwd_ret_out(BWD_RELEASE_RETURN_IN),
    .mir_ret_out(MAIN_INTERLOCK_RETURN_IN),
    .nep_ret_out(NOT_PREPARED_RETURN_IN)
  );

  always #50 SYS_CLK_IN = ~SYS_CLK_IN;

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic pulse(input int i);
    @(posedge SYS_CLK_IN);
    pv[i] <= 1'b1;
    @(posedge SYS_CLK_IN);
    pv[i] <= 1'b0;
    @(negedge SYS_CLK_IN);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge SYS_CLK_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    RD_IN <= 1'b0;
    @(negedge SYS_CLK_IN);
    v = RDATA_OUT;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge SYS_CLK_IN);
    ADDR_IN <= a;
    WDATA_IN <= v;
    WR_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    WR_IN <= 1'b0;
  endtask

  // bounded wait on a design output, checked on falling edges
  task automatic wait_hi(input string n, ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim)
    begin
      @(negedge SYS_CLK_IN);
      k++;
    end
    chk(n, 16'h0001, {15'h0000, k < lim});
  endtask

  task automatic start_sel(input logic [3:0] n);
    pulse(0);
    chk("ctl avail low", 16'h0000, CTL_AVAIL_OUT);
    chk("preset line", 16'h0001, UNIT_SELECT_OUT);
    @(posedge SYS_CLK_IN);
    TAPE_NUM_LSD_IN <= n;
    pulse(1);
    chk("select line", 16'h0001 << n, UNIT_SELECT_OUT);
  endtask

  task automatic opctl(input logic [3:0] dg, input logic cb);
    @(posedge SYS_CLK_IN);
    OPCTL_DIGIT_IN <= dg;
    OPCTL_CHECK_BIT_IN <= cb;
    pulse(2);
    pulse(6);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge SYS_CLK_IN);
    failures++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    failures = 0;
    total_checks = 0;
    {RST_N_IN, WR_IN, RD_IN, OPCTL_CHECK_BIT_IN} = 4'h0;
    CE_IN = 1'b1;
    {TAPE_NUM_LSD_IN, OPCTL_DIGIT_IN, ADDR_IN} = 12'h000;
    WDATA_IN = 16'h0000;
    pv = 9'h000;
    {lat, pf, pb, pwr, ring, stray} = {12'h000, 5'b01110};
    repeat (16) @(posedge SYS_CLK_IN);
    RST_N_IN <= 1'b1;
    @(negedge SYS_CLK_IN);
    chk("dir bwd reset", 16'h0001, DIR_BACKWARD_DECODE_OUT);
    rd(4'h0, d);
    chk("status reset", 16'h0001, d);
    rd(4'hf, d);
    chk("unmapped", 16'h0000, d);
    // prompt unit, backward ready, stray spikes during the hold
    @(posedge SYS_CLK_IN);
    stray <= 1'b1;
    start_sel(4'h3);
    repeat (1390) @(posedge SYS_CLK_IN);
    @(negedge SYS_CLK_IN);
    chk("fwd held", 16'h0000, FWD_RELEASE_FLAG_OUT);
    @(posedge SYS_CLK_IN);
    stray <= 1'b0;
    wait_hi("sample", SELECTION_SAMPLE_PULSE_OUT, 800);
    chk("too many", 16'h0000, TOO_MANY_SELECTED_ERROR_OUT);
    repeat (2) @(negedge SYS_CLK_IN);
    rd(4'h0, d);
    chk("status sel", 16'h1c16, d);
    opctl(4'h5, 1'b1);
    chk("dir fwd", 16'h0001, DIR_FORWARD_DECODE_OUT);
    chk("reverse fwd", 16'h0001, REVERSE_NEEDED_OUT);
    chk("first blk", 16'h0000, FIRST_BLOCK_OUT);
    opctl(4'h4, 1'b0);
    chk("reverse bwd", 16'h0000, REVERSE_NEEDED_OUT);
    rd(4'h3, d);
    chk("dir reg", 16'h0002, d);
    pulse(3);
    chk("none sel ok", 16'h0000, NONE_SELECTED_ERROR_OUT);
    chk("dummy clr", 16'h0000, DUMMY_SELECT_OUT);
    pulse(5);
    chk("ctl avail", 16'h0001, CTL_AVAIL_OUT);
    pulse(4);
    chk("end lines", 16'h0000, UNIT_SELECT_OUT);
    // slow unset unit at first block, later turns available
    @(posedge SYS_CLK_IN);
    {lat, pf, pb, pwr, ring} <= {12'h9c4, 4'b1110};
    start_sel(4'h3);
    wait_hi("sample slow", SELECTION_SAMPLE_PULSE_OUT, 2100);
    repeat (2) @(negedge SYS_CLK_IN);
    chk("interlock", 16'h0001, INTERLOCK_OUT);
    chk("ring", 16'h0000, RING_IN_TAPE_OUT);
    chk("unavail", 16'h0000, UNIT_AVAIL_OUT);
    pulse(7);
    chk("done result", 16'h0001, SEL_DONE_TEST_RESULT_OUT);
    chk("done cleared", 16'h0000, SEL_DONE_OUT);
    wait_hi("avail", UNIT_AVAIL_OUT, 800);
    @(negedge SYS_CLK_IN);
    chk("interlock off", 16'h0000, INTERLOCK_OUT);
    chk("done again", 16'h0001, SEL_DONE_OUT);
    pulse(6);
    chk("first blk set", 16'h0001, FIRST_BLOCK_OUT);
    pulse(4);
    pulse(3);
    chk("none sel", 16'h0001, NONE_SELECTED_ERROR_OUT);
    chk("improper", 16'h0001, IMPROPER_CONN_OUT);
    pulse(8);
    chk("err result", 16'h0001, CTL_ERR_TEST_RESULT_OUT);
    chk("err cleared", 16'h0000, CTL_ERR_OUT);
    wr(4'h0, 16'h0100);
    @(negedge SYS_CLK_IN);
    chk("improper clr", 16'h0000, IMPROPER_CONN_OUT);
    // selection ended at once, then a stray release arrives
    pulse(0);
    pulse(4);
    @(posedge SYS_CLK_IN);
    stray <= 1'b1;
    wait_hi("sample idle", SELECTION_SAMPLE_PULSE_OUT, 2100);
    repeat (3) @(negedge SYS_CLK_IN);
    chk("fwd blocked", 16'h0000, FWD_RELEASE_FLAG_OUT);
    chk("no avail", 16'h0000, UNIT_AVAIL_OUT);
    // dummy left set by the last sample meets a fresh select line
    start_sel(4'h5);
    wait_hi("sample stale", SELECTION_SAMPLE_PULSE_OUT, 2100);
    chk("too many set", 16'h0001, TOO_MANY_SELECTED_ERROR_OUT);
    chk("err too many", 16'h0001, CTL_ERR_OUT);
    print_verdict();
  end
endmodule
